// file: escr_pkg.sv
// escr_pkg: register map, field positions, reset values and sampling periods
// assumes a byte-wide register port fed by an external serial slave engine
package escr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h07;
  localparam logic [7:0] ADDR_TEMP_LO  = 8'h0a;
  localparam logic [7:0] ADDR_TEMP_HI  = 8'h0b;
  localparam logic [7:0] ADDR_HUM_LO   = 8'h0c;
  localparam logic [7:0] ADDR_HUM_HI   = 8'h0d;
  localparam logic [7:0] ADDR_CFG      = 8'h0e;
  localparam logic [7:0] ADDR_MEAS     = 8'h0f;
  localparam logic [7:0] ADDR_MAKER_LO = 8'hfc;
  localparam logic [7:0] ADDR_MAKER_HI = 8'hfd;
  localparam logic [7:0] ADDR_PART_LO  = 8'hfe;
  localparam logic [7:0] ADDR_PART_HI  = 8'hff;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TEMP_LO_RST = 8'h00;
  localparam logic [7:0] TEMP_HI_RST = 8'hff;
  localparam logic [7:0] HUM_LO_RST  = 8'h00;
  localparam logic [7:0] HUM_HI_RST  = 8'hff;
  localparam logic [7:0] CFG_RST     = 8'h00;
  localparam logic [7:0] MEAS_RST    = 8'h00;
  localparam logic [4:0] IRQ_EN_RST  = 5'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_SRST     = 7;
  localparam int CFG_RATE_MSB = 6;
  localparam int CFG_RATE_LSB = 4;
  localparam int CFG_HEAT     = 3;
  localparam int CFG_PIN_EN   = 2;
  localparam int CFG_POL      = 1;
  localparam int CFG_MODE     = 0;
  localparam int MEAS_TEMP_RESOLUTION    = 6;
  localparam int MEAS_HUMIDITY_RESOLUTION    = 4;
  localparam int MEAS_CHAN    = 1;
  localparam int MEAS_START   = 0;
  localparam int IRQ_EN_LSB   = 3;
  localparam logic [1:0] CHAN_TEMP_ONLY = 2'h1;

  // flag and enable order, matching enable bits 7..3
  localparam int FL_DRDY = 4;
  localparam int FL_TH   = 3;
  localparam int FL_TL   = 2;
  localparam int FL_HH   = 1;
  localparam int FL_HL   = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ       = 20_000_000;
  localparam longint CYC_PER_MS   = CLK_HZ / 1000;
  localparam longint RATE1_MS     = 120_000;
  localparam longint RATE2_MS     = 60_000;
  localparam longint RATE3_MS     = 10_000;
  localparam longint RATE4_MS     = 5_000;
  localparam longint RATE5_MS     = 1_000;
  localparam longint RATE6_MS     = 500;
  localparam longint RATE7_MS     = 200;
  localparam int unsigned RATE1_CYC = 32'(RATE1_MS * CYC_PER_MS);
  localparam int unsigned RATE2_CYC = 32'(RATE2_MS * CYC_PER_MS);
  localparam int unsigned RATE3_CYC = 32'(RATE3_MS * CYC_PER_MS);
  localparam int unsigned RATE4_CYC = 32'(RATE4_MS * CYC_PER_MS);
  localparam int unsigned RATE5_CYC = 32'(RATE5_MS * CYC_PER_MS);
  localparam int unsigned RATE6_CYC = 32'(RATE6_MS * CYC_PER_MS);
  localparam int unsigned RATE7_CYC = 32'(RATE7_MS * CYC_PER_MS);

endpackage

// file: escr_timer_if.sv
// escr_timer_if: link between the register bank and the sampling timer
// assumes both ends run on MCLK
interface escr_timer_if;
  logic [2:0] rate;
  logic       restart;
  logic       tick;
  modport ctl (output rate, output restart, input tick);
  modport tmr (input rate, input restart, output tick);
endinterface

// file: escr_timer.sv
// escr_timer: periodic sampling tick generator
// assumes rate and restart come from MCLK logic
module escr_timer
  import escr_pkg::*;
#(
  parameter int unsigned P1 = RATE1_CYC,
  parameter int unsigned P2 = RATE2_CYC,
  parameter int unsigned P3 = RATE3_CYC,
  parameter int unsigned P4 = RATE4_CYC,
  parameter int unsigned P5 = RATE5_CYC,
  parameter int unsigned P6 = RATE6_CYC,
  parameter int unsigned P7 = RATE7_CYC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // control
  escr_timer_if.tmr tif
);

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        tick_ff;
  logic        nxt_tick;

  // ----------------------------------------------------------------
  // period lookup
  // ----------------------------------------------------------------
  function automatic logic [31:0] period(input logic [2:0] code);
    case (code)
      3'h1:    period = P1;
      3'h2:    period = P2;
      3'h3:    period = P3;
      3'h4:    period = P4;
      3'h5:    period = P5;
      3'h6:    period = P6;
      3'h7:    period = P7;
      default: period = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // periodic conversion tick
  always_comb begin
    nxt_cnt  = cnt_ff + 32'h0000_0001;
    nxt_tick = 1'b0;
    if (tif.restart || tif.rate == 3'h0) begin
      nxt_cnt = 32'h0000_0000;
    end else if (cnt_ff >= period(tif.rate) - 32'h0000_0001) begin
      nxt_cnt  = 32'h0000_0000;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_ff  <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tif.tick = tick_ff;

  chk_idle_no_tick: assert property (@(posedge MCLK) disable iff (!RST_N)
    (tif.rate == 3'h0) |=> ##1 !tif.tick)
    else $error("tick while automatic sampling off");

endmodule

// file: escr_regs.sv
// escr_regs: limit, configuration, conversion setup and identity registers
// assumes a byte register port and a converter that answers with a done pulse
module escr_regs
  import escr_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'h5a5a, // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h0123, // arbitrary value
  parameter int unsigned AUTO_P1    = RATE1_CYC,
  parameter int unsigned AUTO_P2    = RATE2_CYC,
  parameter int unsigned AUTO_P3    = RATE3_CYC,
  parameter int unsigned AUTO_P4    = RATE4_CYC,
  parameter int unsigned AUTO_P5    = RATE5_CYC,
  parameter int unsigned AUTO_P6    = RATE6_CYC,
  parameter int unsigned AUTO_P7    = RATE7_CYC
) (
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  // register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // converter
  output logic            CONV_REQ,
  input  wire logic       CONV_DONE,
  input  wire logic [7:0] TEMP_RESULT,
  input  wire logic [7:0] HUM_RESULT,
  output logic      [1:0] TEMP_RES,
  output logic      [1:0] HUM_RES,
  output logic      [1:0] CHAN_SEL,
  output logic            HEATER_ON,
  output logic            NV_RELOAD,
  // interrupt pin
  input  wire logic       IRQ_ACK,
  output logic            IRQ_O,
  output logic            IRQ_OE_N
);

  logic [7:0] temp_lo_ff, temp_hi_ff, hum_lo_ff, hum_hi_ff, cfg_ff, meas_ff;
  logic [7:0] nxt_temp_lo, nxt_temp_hi, nxt_hum_lo, nxt_hum_hi, nxt_cfg, nxt_meas;
  logic [4:0] irq_en_ff, nxt_irq_en, flags_ff, nxt_flags, hits;
  logic       srst_ff, nxt_srst, busy_ff, nxt_busy, req_ff, nxt_req;
  logic       irq_o_ff, nxt_irq_o, irq_act;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       wr_cfg, wr_meas, start_wr, done;
  escr_timer_if tif ();
  // ----------------------------------------------------------------
  // sampling timer
  // ----------------------------------------------------------------
  escr_timer #(
    .P1 (AUTO_P1), .P2 (AUTO_P2), .P3 (AUTO_P3), .P4 (AUTO_P4),
    .P5 (AUTO_P5), .P6 (AUTO_P6), .P7 (AUTO_P7)
  ) u_timer (
    .MCLK (MCLK), .RST_N (RST_N), .tif (tif.tmr)
  );

  assign tif.rate    = cfg_ff[CFG_RATE_MSB:CFG_RATE_LSB];
  assign tif.restart = srst_ff | wr_cfg;
  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  assign wr_cfg   = REG_WR && REG_ADDR == ADDR_CFG;
  assign wr_meas  = REG_WR && REG_ADDR == ADDR_MEAS;
  assign start_wr = wr_meas && REG_WDATA[MEAS_START];
  assign done     = CONV_DONE && busy_ff;

  always_comb begin
    nxt_temp_lo = temp_lo_ff;
    nxt_temp_hi = temp_hi_ff;
    nxt_hum_lo  = hum_lo_ff;
    nxt_hum_hi  = hum_hi_ff;
    nxt_cfg     = cfg_ff;
    nxt_meas    = meas_ff;
    nxt_irq_en  = irq_en_ff;
    nxt_srst    = 1'b0;
    if (srst_ff) begin
      nxt_temp_lo = TEMP_LO_RST;
      nxt_temp_hi = TEMP_HI_RST;
      nxt_hum_lo  = HUM_LO_RST;
      nxt_hum_hi  = HUM_HI_RST;
      nxt_cfg     = CFG_RST;
      nxt_meas    = MEAS_RST;
      nxt_irq_en  = IRQ_EN_RST;
    end else begin
      if (done) begin
        nxt_meas[MEAS_START] = 1'b0;
      end
      if (REG_WR) begin
        case (REG_ADDR)
          ADDR_IRQ_EN:  nxt_irq_en  = REG_WDATA[7:IRQ_EN_LSB];
          ADDR_TEMP_LO: nxt_temp_lo = REG_WDATA;
          ADDR_TEMP_HI: nxt_temp_hi = REG_WDATA;
          ADDR_HUM_LO:  nxt_hum_lo  = REG_WDATA;
          ADDR_HUM_HI:  nxt_hum_hi  = REG_WDATA;
          ADDR_CFG: begin
            nxt_cfg           = REG_WDATA;
            nxt_cfg[CFG_SRST] = 1'b0;
            nxt_srst          = REG_WDATA[CFG_SRST];
          end
          ADDR_MEAS: begin
            nxt_meas             = REG_WDATA;
            nxt_meas[MEAS_START] = REG_WDATA[MEAS_START] | (meas_ff[MEAS_START] & ~done);
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      temp_lo_ff <= TEMP_LO_RST;
      temp_hi_ff <= TEMP_HI_RST;
      hum_lo_ff  <= HUM_LO_RST;
      hum_hi_ff  <= HUM_HI_RST;
      cfg_ff     <= CFG_RST;
      meas_ff    <= MEAS_RST;
      irq_en_ff  <= IRQ_EN_RST;
      srst_ff    <= 1'b0;
    end else begin
      temp_lo_ff <= nxt_temp_lo;
      temp_hi_ff <= nxt_temp_hi;
      hum_lo_ff  <= nxt_hum_lo;
      hum_hi_ff  <= nxt_hum_hi;
      cfg_ff     <= nxt_cfg;
      meas_ff    <= nxt_meas;
      irq_en_ff  <= nxt_irq_en;
      srst_ff    <= nxt_srst;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_req  = !busy_ff && !srst_ff && (start_wr || tif.tick);
    nxt_busy = busy_ff;
    if (srst_ff || done) begin
      nxt_busy = 1'b0;
    end else if (nxt_req) begin
      nxt_busy = 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      req_ff  <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      req_ff  <= nxt_req;
      busy_ff <= nxt_busy;
    end
  end

  // ----------------------------------------------------------------
  // limit compare and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    hits          = 5'h00;
    hits[FL_DRDY] = 1'b1;
    hits[FL_TH]   = TEMP_RESULT > temp_hi_ff;
    hits[FL_TL]   = TEMP_RESULT < temp_lo_ff;
    if (meas_ff[MEAS_CHAN +: 2] != CHAN_TEMP_ONLY) begin
      hits[FL_HH] = HUM_RESULT > hum_hi_ff;
      hits[FL_HL] = HUM_RESULT < hum_lo_ff;
    end
    hits = hits & irq_en_ff;
    nxt_flags = flags_ff;
    if (srst_ff) begin
      nxt_flags = 5'h00;
    end else if (cfg_ff[CFG_MODE]) begin
      if (IRQ_ACK) begin
        nxt_flags[FL_DRDY] = 1'b0;
      end
      if (done) begin
        nxt_flags = {nxt_flags[FL_DRDY] | hits[FL_DRDY], hits[3:0]};
      end
    end else begin
      if (IRQ_ACK) begin
        nxt_flags = 5'h00;
      end
      if (done) begin
        nxt_flags = nxt_flags | hits;
      end
    end
    irq_act = |flags_ff;
    nxt_irq_o = cfg_ff[CFG_POL] ? irq_act : !irq_act;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_ff <= 5'h00;
      irq_o_ff <= 1'b1;
    end else begin
      flags_ff <= nxt_flags;
      irq_o_ff <= nxt_irq_o;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = rdata_ff;
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_IRQ_EN:   nxt_rdata = {irq_en_ff, 3'h0};
        ADDR_TEMP_LO:  nxt_rdata = temp_lo_ff;
        ADDR_TEMP_HI:  nxt_rdata = temp_hi_ff;
        ADDR_HUM_LO:   nxt_rdata = hum_lo_ff;
        ADDR_HUM_HI:   nxt_rdata = hum_hi_ff;
        ADDR_CFG:      nxt_rdata = cfg_ff;
        ADDR_MEAS:     nxt_rdata = meas_ff;
        ADDR_MAKER_LO: nxt_rdata = MAKER_CODE[7:0];
        ADDR_MAKER_HI: nxt_rdata = MAKER_CODE[15:8];
        ADDR_PART_LO:  nxt_rdata = PART_CODE[7:0];
        ADDR_PART_HI:  nxt_rdata = PART_CODE[15:8];
        default:       nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign REG_RDATA = rdata_ff;
  assign CONV_REQ  = req_ff;
  assign NV_RELOAD = srst_ff;
  assign TEMP_RES  = meas_ff[MEAS_TEMP_RESOLUTION +: 2];
  assign HUM_RES   = meas_ff[MEAS_HUMIDITY_RESOLUTION +: 2];
  assign CHAN_SEL  = meas_ff[MEAS_CHAN +: 2];
  assign HEATER_ON = cfg_ff[CFG_HEAT];
  assign IRQ_OE_N  = !cfg_ff[CFG_PIN_EN];
  assign IRQ_O     = irq_o_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  chk_temp_hi_rst: assert property (srst_ff |=> temp_hi_ff == TEMP_HI_RST)
    else $error("upper temperature limit not restored");
  chk_hum_lo_rst: assert property (srst_ff |=> hum_lo_ff == HUM_LO_RST)
    else $error("lower humidity limit not restored");
  chk_hum_hi_rst: assert property (srst_ff |=> hum_hi_ff == HUM_HI_RST)
    else $error("upper humidity limit not restored");
  chk_srst_pulse: assert property (wr_cfg && REG_WDATA[CFG_SRST] |=>
    srst_ff && !cfg_ff[CFG_SRST] ##1 !srst_ff && cfg_ff == CFG_RST && !busy_ff)
    else $error("soft reset sequence wrong");
  chk_start_req: assert property (start_wr && !busy_ff && !srst_ff |=>
    CONV_REQ && busy_ff ##1 !CONV_REQ)
    else $error("start write gave no single request");
  chk_start_clr: assert property (done && !wr_meas && !srst_ff |=>
    !meas_ff[MEAS_START] && !busy_ff)
    else $error("start bit not cleared at end of conversion");
  chk_manual_req: assert property (tif.rate == 3'h0 && !start_wr |=> !CONV_REQ)
    else $error("request without host start in manual mode");
  chk_heater_wr: assert property (wr_cfg && !srst_ff |=>
    HEATER_ON == $past(REG_WDATA[CFG_HEAT]))
    else $error("heater does not follow write");
  chk_pin_hiz: assert property (wr_cfg && !srst_ff && !REG_WDATA[CFG_PIN_EN] |=> IRQ_OE_N)
    else $error("pin driven while disabled");
  chk_pin_pol: assert property (irq_act |=> IRQ_O == $past(cfg_ff[CFG_POL]))
    else $error("interrupt level has wrong polarity");
  chk_th_fire: assert property (done && !srst_ff && irq_en_ff[FL_TH] &&
    TEMP_RESULT > temp_hi_ff |=> flags_ff[FL_TH] ##1 IRQ_O == cfg_ff[CFG_POL])
    else $error("temperature high generator did not fire");
  chk_level_hold: assert property (!cfg_ff[CFG_MODE] && flags_ff[FL_TL] &&
    !IRQ_ACK && !srst_ff |=> flags_ff[FL_TL])
    else $error("level flag lost without ack");
  chk_maker_lo: assert property (REG_RD && REG_ADDR == ADDR_MAKER_LO |=>
    REG_RDATA == MAKER_CODE[7:0])
    else $error("maker code low byte wrong");
  chk_part_hi: assert property (REG_RD && REG_ADDR == ADDR_PART_HI |=>
    REG_RDATA == PART_CODE[15:8])
    else $error("part code high byte wrong");
  cov_manual_conv: cover property (start_wr ##1 CONV_REQ ##[1:50] done);
  cov_auto_conv: cover property (tif.tick ##1 CONV_REQ);
  cov_soft_reset: cover property (wr_cfg && REG_WDATA[CFG_SRST] ##2 NV_RELOAD == 1'b0);
  cov_irq_fire: cover property (done && |hits ##2 irq_act);
endmodule

// file: escr_conv_model.sv
// escr_conv_model: converter stand-in answering conversion requests
// assumes one request at a time, latency set by the bench
module escr_conv_model (
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  // bench setup
  input  wire logic [7:0] LAT,
  input  wire logic [7:0] T_IN,
  input  wire logic [7:0] H_IN,
  // converter side
  input  wire logic       CONV_REQ,
  output logic            CONV_DONE,
  output logic      [7:0] TEMP_RESULT,
  output logic      [7:0] HUM_RESULT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  logic       busy_ff;
  // results valid only in the done cycle, toggling otherwise
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_ff      <= 8'h00;
      busy_ff     <= 1'b0;
      CONV_DONE   <= 1'b0;
      TEMP_RESULT <= 8'h00;
      HUM_RESULT  <= 8'h00;
    end else begin
      CONV_DONE   <= 1'b0;
      TEMP_RESULT <= ~TEMP_RESULT;
      HUM_RESULT  <= ~HUM_RESULT;
      if (CONV_REQ) begin
        busy_ff <= 1'b1;
        cnt_ff  <= LAT;
      end else if (busy_ff && cnt_ff != 8'h00) begin
        cnt_ff <= cnt_ff - 8'h01;
      end else if (busy_ff) begin
        busy_ff     <= 1'b0;
        CONV_DONE   <= 1'b1;
        TEMP_RESULT <= T_IN;
        HUM_RESULT  <= H_IN;
      end
    end
  end
endmodule

// file: tb_escr_regs.sv
// tb_escr_regs: self-checking bench for the register bank
// assumes escr_pkg, escr_timer_if, escr_timer and escr_regs compiled first
module tb_escr_regs
  import escr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MK = 16'h1357; // arbitrary value
  localparam logic [15:0] PK = 16'h2468; // arbitrary value
  // shortened sampling periods, four cycles per code step
  localparam int unsigned AP1 = 40, AP2 = 36, AP3 = 32, AP4 = 28;
  localparam int unsigned AP5 = 24, AP6 = 20, AP7 = 16;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       irq_ack = 1'b0;
  logic [7:0] lat = 8'h14;
  logic [7:0] t_in = 8'h00;
  logic [7:0] h_in = 8'h00;
  logic [7:0] setup_bits = 8'h00;
  logic [7:0] rdata, t_res8, h_res8;
  logic [1:0] temp_res, hum_res, chan_sel;
  logic       conv_req, conv_done, heater_on, nv_reload, irq_o, irq_oe_n;
  int         num_errors = 0;
  int         samples_checked = 0;

  always #25 mclk = ~mclk;

  escr_regs #(.MAKER_CODE(MK), .PART_CODE(PK), .AUTO_P1(AP1), .AUTO_P2(AP2),
    .AUTO_P3(AP3), .AUTO_P4(AP4), .AUTO_P5(AP5), .AUTO_P6(AP6), .AUTO_P7(AP7)) dut (
    .MCLK(mclk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .CONV_REQ(conv_req), .CONV_DONE(conv_done),
    .TEMP_RESULT(t_res8), .HUM_RESULT(h_res8), .TEMP_RES(temp_res), .HUM_RES(hum_res),
    .CHAN_SEL(chan_sel), .HEATER_ON(heater_on), .NV_RELOAD(nv_reload),
    .IRQ_ACK(irq_ack), .IRQ_O(irq_o), .IRQ_OE_N(irq_oe_n));

  escr_conv_model conv (.MCLK(mclk), .RST_N(rst_n), .LAT(lat), .T_IN(t_in),
    .H_IN(h_in), .CONV_REQ(conv_req), .CONV_DONE(conv_done),
    .TEMP_RESULT(t_res8), .HUM_RESULT(h_res8));

  // ----------------------------------------------------------------
  // bus and check helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    #1;
    chk(nm, rdata, exp);
  endtask

  // sel 0 request, 1 done, 2 reload; n counts edges
  task automatic wait_for(input int sel, input int lim, output int n);
    logic hit;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
      hit = (sel == 0) ? conv_req : (sel == 1) ? conv_done : nv_reload;
    end while (hit !== 1'b1 && n < lim);
    if (hit !== 1'b1) begin
      num_errors++;
      $display("unexpected timeout on wait %0d", sel);
      tally_and_finish();
    end
  endtask

  // setup bits go out with the start bit, then wait for done
  task automatic convert(input logic [7:0] t);
    int n;
    t_in = t;
    wr_reg(ADDR_MEAS, setup_bits | 8'h01);
    wait_for(1, 60, n);
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic ack();
    @(posedge mclk);
    irq_ack <= 1'b1;
    @(posedge mclk);
    irq_ack <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals();
    rd_chk("temp_upper_limit", ADDR_TEMP_HI, 8'hff);
    rd_chk("humidity_lower_limit", ADDR_HUM_LO, 8'h00);
    rd_chk("humidity_upper_limit", ADDR_HUM_HI, 8'hff);
    rd_chk("temp_lower_limit", ADDR_TEMP_LO, 8'h00);
    rd_chk("irq_enables", ADDR_IRQ_EN, 8'h00);
    rd_chk("device_configuration", ADDR_CFG, 8'h00);
    rd_chk("conversion_setup", ADDR_MEAS, 8'h00);
    rd_chk("maker_code_low", ADDR_MAKER_LO, MK[7:0]);
    rd_chk("maker_code_high", ADDR_MAKER_HI, MK[15:8]);
    rd_chk("part_code_low", ADDR_PART_LO, PK[7:0]);
    rd_chk("part_code_high", ADDR_PART_HI, PK[15:8]);
    chk("irq_oe_n", {7'h0, irq_oe_n}, 8'h01);
    chk("irq_o_idle", {7'h0, irq_o}, 8'h01);
  endtask

  task automatic t_limits_rw();
    wr_reg(ADDR_TEMP_HI, 8'h00);
    wr_reg(ADDR_HUM_LO, 8'hff);
    wr_reg(ADDR_HUM_HI, 8'h01);
    wr_reg(ADDR_MAKER_LO, 8'h00);
    wr_reg(ADDR_PART_HI, 8'h00);
    rd_chk("temp_upper_limit", ADDR_TEMP_HI, 8'h00);
    rd_chk("humidity_lower_limit", ADDR_HUM_LO, 8'hff);
    rd_chk("humidity_upper_limit", ADDR_HUM_HI, 8'h01);
    rd_chk("maker_code_low", ADDR_MAKER_LO, MK[7:0]);
    rd_chk("part_code_high", ADDR_PART_HI, PK[15:8]);
    rd_chk("unmapped", 8'h20, 8'h00);
  endtask

  task automatic t_setup_fields();
    wr_reg(ADDR_CFG, 8'h0c);
    wr_reg(ADDR_MEAS, 8'h92);
    chk("heater_on", {7'h0, heater_on}, 8'h01);
    chk("irq_oe_n", {7'h0, irq_oe_n}, 8'h00);
    chk("setup_fields", {temp_res, hum_res, 2'b00, chan_sel}, 8'h91);
    rd_chk("conversion_setup", ADDR_MEAS, 8'h92);
    wr_reg(ADDR_MEAS, 8'h64);
    wr_reg(ADDR_CFG, 8'h00);
    chk("setup_fields", {temp_res, hum_res, 2'b00, chan_sel}, 8'h62);
    chk("heater_on", {7'h0, heater_on}, 8'h00);
    wr_reg(ADDR_MEAS, 8'h00);
  endtask

  task automatic t_trigger();
    int n;
    n = 0;
    repeat (60) begin
      @(posedge mclk);
      #1;
      if (conv_req === 1'b1) n++;
    end
    chk("idle_requests", n[7:0], 8'h00);
    wr_reg(ADDR_MEAS, 8'h01);
    chk("request_pulse", {7'h0, conv_req}, 8'h01);
    @(posedge mclk);
    #1;
    chk("request_single", {7'h0, conv_req}, 8'h00);
    rd_chk("start_bit_busy", ADDR_MEAS, 8'h01);
    wait_for(1, 40, n);
    rd_chk("start_bit_done", ADDR_MEAS, 8'h00);
  endtask

  task automatic t_irq();
    lat = 8'h02;
    wr_reg(ADDR_CFG, 8'h06);
    wr_reg(ADDR_IRQ_EN, 8'h40);
    wr_reg(ADDR_TEMP_HI, 8'h10);
    convert(8'h20);
    chk("irq_high_fire", {7'h0, irq_o}, 8'h01);
    convert(8'h05);
    chk("irq_level_sticky", {7'h0, irq_o}, 8'h01);
    ack();
    chk("irq_acked", {7'h0, irq_o}, 8'h00);
    convert(8'h10);
    chk("irq_equal_limit", {7'h0, irq_o}, 8'h00);
    wr_reg(ADDR_IRQ_EN, 8'h00);
    convert(8'h30);
    chk("irq_disabled", {7'h0, irq_o}, 8'h00);
    wr_reg(ADDR_CFG, 8'h07);
    wr_reg(ADDR_IRQ_EN, 8'h40);
    convert(8'h30);
    chk("irq_comparator_set", {7'h0, irq_o}, 8'h01);
    convert(8'h05);
    chk("irq_comparator_clear", {7'h0, irq_o}, 8'h00);
    wr_reg(ADDR_CFG, 8'h04);
    @(posedge mclk);
    #1;
    chk("irq_active_low_idle", {7'h0, irq_o}, 8'h01);
  endtask

  task automatic t_humidity();
    h_in = 8'h90;
    wr_reg(ADDR_CFG, 8'h06);
    wr_reg(ADDR_HUM_HI, 8'h80);
    wr_reg(ADDR_IRQ_EN, 8'h10);
    convert(8'h80);
    chk("irq_hum_high_fire", {7'h0, irq_o}, 8'h01);
    ack();
    chk("irq_hum_high_acked", {7'h0, irq_o}, 8'h00);
    setup_bits = 8'h02;
    convert(8'h80);
    chk("irq_hum_skipped", {7'h0, irq_o}, 8'h00);
    setup_bits = 8'h00;
    h_in = 8'h10;
    wr_reg(ADDR_HUM_LO, 8'h20);
    wr_reg(ADDR_IRQ_EN, 8'h08);
    convert(8'h80);
    chk("irq_hum_low_fire", {7'h0, irq_o}, 8'h01);
    ack();
    wr_reg(ADDR_IRQ_EN, 8'h80);
    convert(8'h80);
    chk("irq_ready_fire", {7'h0, irq_o}, 8'h01);
    ack();
  endtask

  task automatic t_auto();
    int n;
    int p;
    for (int code = 1; code < 8; code++) begin
      p = AP7 + 4 * (7 - code);
      wr_reg(ADDR_CFG, {1'b0, 3'(code), 4'h0});
      wait_for(0, p + 8, n);
      chk("auto_period", {7'h0, n >= p - 3 && n <= p + 4}, 8'h01);
    end
    wr_reg(ADDR_CFG, 8'h00);
  endtask

  task automatic t_soft_reset();
    wr_reg(ADDR_TEMP_HI, 8'h33);
    wr_reg(ADDR_IRQ_EN, 8'hf8);
    wr_reg(ADDR_CFG, 8'h88);
    chk("reload_pulse", {7'h0, nv_reload}, 8'h01);
    @(posedge mclk);
    #1;
    chk("reload_single", {7'h0, nv_reload}, 8'h00);
    rd_chk("temp_upper_limit", ADDR_TEMP_HI, 8'hff);
    rd_chk("irq_enables", ADDR_IRQ_EN, 8'h00);
    rd_chk("device_configuration", ADDR_CFG, 8'h00);
    chk("heater_on", {7'h0, heater_on}, 8'h00);
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset_vals();
    t_limits_rw();
    t_setup_fields();
    t_trigger();
    t_irq();
    t_humidity();
    t_auto();
    t_soft_reset();
    tally_and_finish();
  end
endmodule
